// *** common/slc_defs.vh ***
// Register offsets, field positions, reset values and level codes of the LCD pin control
`ifndef SLC_DEFS_VH
`define SLC_DEFS_VH
`define SLC_OFS_MAIN 6'h00
`define SLC_OFS_ROLE 6'h04
`define SLC_OFS_SEGA 6'h08
`define SLC_OFS_SEGB 6'h0C
`define SLC_OFS_SEGC 6'h10
`define SLC_OFS_STAT 6'h14
`define SLC_RST_BYTE 8'h00
`define SLC_BIT_FRAME 7
`define SLC_BIT_ISEL_HI 6
`define SLC_BIT_ISEL_LO 5
`define SLC_BIT_MASTER 4
`define SLC_BIT_DUAL4_EN 6
`define SLC_BIT_DUAL5_EN 7
`define SLC_BIT_DUAL3_EN 3
`define SLC_BIT_STAT_DIV 5
`define SLC_BIT_STAT_FRAME 4
`define SLC_SEG14_IDX 8
`define SLC_SEG15_IDX 9
`define SLC_RST_WORD 32'h00000000
`define SLC_LVL_VSS 2'h0
`define SLC_LVL_THIRD 2'h1
`define SLC_LVL_TWOTHIRD 2'h2
`define SLC_LVL_VDD 2'h3
`define SLC_HTRANS_NONSEQ 2'h2
`endif

// *** hdl/slc_top.v ***
// AHB-Lite register bank and pin level selection for the software LCD driver
`timescale 1ns/1ns
`default_nettype none
`include "slc_defs.vh"
// Overview of operation
// RQ1: Master off drives all LCD pins ground
// RQ2: Pin LCD only when pin and master set
// RQ3: Master enable switches bias divider path
// RQ4: Bit 7 picks frame 0 or 1
// RQ5: Bits 6-5 give bias current code out
// RQ6: Dual pin enable picks LCD over other
// RQ7: Role bit: 0 common, 1 segment
// RQ8: Segment pins 6-29 have own enables
// RQ9: Oscillator use blocks segments 14 and 15
// RQ10: LCD drive ignores port direction setting
// RQ11: Dual pin enables assign common pins; the code makes an enabled pin common or segment by its role bit
// RQ12: Pin polarity comes from I/O data bit
// RQ13: Frame 0 levels: common VDD/third, segment VSS/twothird
// RQ14: Frame 1 levels swap both pin kinds
module slc_top #(
    parameter NDUAL = 6,
    parameter NSEG = 24
) (
    input wire hclk, // System clock
    input wire hresetn, // Asynchronous reset, active low
    input wire clk_en, // Freezes all state while low
    input wire hsel, // Slave select
    input wire [31:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write when high
    input wire [2:0] hsize, // Transfer size
    input wire [31:0] hwdata, // Write data
    input wire hready, // Bus ready in
    output reg [31:0] hrdata, // Read data
    output reg hreadyout, // Slave ready
    output reg hresp, // Always OKAY
    input wire [NDUAL-1:0] dual_pin_data, // I/O data bits of dual pins
    input wire [NSEG-1:0] seg_pin_data, // I/O data bits of segment pins 6..29
    input wire osc_on_seg14, // Pin of segment 14 claimed by oscillator
    input wire osc_on_seg15, // Pin of segment 15 claimed by oscillator
    output reg lcd_master_on, // Master enable copy
    output reg bias_divider_on, // Bias resistor path on
    output reg [1:0] bias_current_code, // Bias current select
    output reg frame_sel, // Current frame
    output reg [NDUAL-1:0] dual_pin_lcd_sel, // Dual pin taken by LCD mux
    output reg [NSEG-1:0] seg_pin_lcd_sel, // Segment pin taken by LCD mux
    output reg [2*NDUAL-1:0] dual_pin_level, // Two-bit level per dual pin
    output reg [2*NSEG-1:0] seg_pin_level // Two-bit level per segment pin
);
    // Register index codes produced by the address decoder
    localparam [2:0] IDX_MAIN = 3'h0;
    localparam [2:0] IDX_ROLE = 3'h1;
    localparam [2:0] IDX_SEGA = 3'h2;
    localparam [2:0] IDX_SEGB = 3'h3;
    localparam [2:0] IDX_SEGC = 3'h4;
    localparam [2:0] IDX_STAT = 3'h5;
    localparam [2:0] IDX_NONE = 3'h7;

    // Programmable registers and their next values
    reg [7:0] main_r;
    reg [7:0] main_nxt;
    reg [7:0] role_r;
    reg [7:0] role_nxt;
    reg [7:0] sega_r;
    reg [7:0] sega_nxt;
    reg [7:0] segb_r;
    reg [7:0] segb_nxt;
    reg [7:0] segc_r;
    reg [7:0] segc_nxt;

    // Bus pipeline: write index captured in the address phase
    reg wr_pend_r;
    reg [2:0] wr_idx_r;
    reg [31:0] hrdata_nxt;
    wire take;
    wire take_rd;
    wire take_wr;
    wire [2:0] addr_idx;
    wire main_we;
    wire role_we;
    wire sega_we;
    wire segb_we;
    wire segc_we;

    // Pin function selection
    wire master;
    wire frame;
    wire [1:0] isel;
    wire [NDUAL-1:0] dual_en;
    wire [NDUAL-1:0] dual_role;
    wire [NDUAL-1:0] dual_act;
    wire [2*NDUAL-1:0] dual_lvl_nxt;
    wire [NSEG-1:0] seg_en_raw;
    wire [NSEG-1:0] osc_claim;
    wire [NSEG-1:0] seg_en;
    wire [NSEG-1:0] seg_act;
    wire [2*NSEG-1:0] seg_lvl_nxt;

    // Maps a byte offset to a register index; shared by read and write paths
    function [2:0] reg_index;
        input [5:0] ofs;
        begin
            case (ofs)
                `SLC_OFS_MAIN: reg_index = IDX_MAIN;
                `SLC_OFS_ROLE: reg_index = IDX_ROLE;
                `SLC_OFS_SEGA: reg_index = IDX_SEGA;
                `SLC_OFS_SEGB: reg_index = IDX_SEGB;
                `SLC_OFS_SEGC: reg_index = IDX_SEGC;
                `SLC_OFS_STAT: reg_index = IDX_STAT;
                default: reg_index = IDX_NONE;
            endcase
        end
    endfunction

    // Level code for one pin: common pins idle high in frame 0, segments low
    function [1:0] pin_level;
        input act;
        input is_seg;
        input frm;
        input data;
        begin
            if (!act) begin
                pin_level = `SLC_LVL_VSS;
            end else if (is_seg ^ frm) begin
                pin_level = data ? `SLC_LVL_TWOTHIRD : `SLC_LVL_VSS;
            end else begin
                pin_level = data ? `SLC_LVL_VDD : `SLC_LVL_THIRD;
            end
        end
    endfunction

    assign master = main_r[`SLC_BIT_MASTER];
    assign frame = main_r[`SLC_BIT_FRAME];
    assign isel = main_r[`SLC_BIT_ISEL_HI:`SLC_BIT_ISEL_LO];
    // RQ11 enables in two registers
    assign dual_en = {role_r[`SLC_BIT_DUAL5_EN:`SLC_BIT_DUAL4_EN], main_r[`SLC_BIT_DUAL3_EN:0]};
    // RQ7 role bits
    assign dual_role = role_r[NDUAL-1:0];
    // RQ8 three segment registers
    assign seg_en_raw = {segc_r, segb_r, sega_r};

    // Address phase decode; hsize is ignored, only the low byte lane is kept
    assign take = hsel & hready & (htrans == `SLC_HTRANS_NONSEQ);
    assign take_rd = take & ~hwrite;
    assign take_wr = take & hwrite;
    assign addr_idx = reg_index(haddr[5:0]);

    // Data phase write strobes; unmapped indexes change nothing
    // RQ4 frame, RQ5 current, master
    assign main_we = wr_pend_r & (wr_idx_r == IDX_MAIN);
    // RQ7 role bits
    assign role_we = wr_pend_r & (wr_idx_r == IDX_ROLE);
    assign sega_we = wr_pend_r & (wr_idx_r == IDX_SEGA);
    assign segb_we = wr_pend_r & (wr_idx_r == IDX_SEGB);
    assign segc_we = wr_pend_r & (wr_idx_r == IDX_SEGC);

    // A register keeps its byte unless its strobe is up
    always @* begin
        main_nxt = main_r;
        if (main_we) begin
            main_nxt = hwdata[7:0];
        end
    end

    always @* begin
        role_nxt = role_r;
        if (role_we) begin
            role_nxt = hwdata[7:0];
        end
    end

    always @* begin
        sega_nxt = sega_r;
        if (sega_we) begin
            sega_nxt = hwdata[7:0];
        end
    end

    always @* begin
        segb_nxt = segb_r;
        if (segb_we) begin
            segb_nxt = hwdata[7:0];
        end
    end

    always @* begin
        segc_nxt = segc_r;
        if (segc_we) begin
            segc_nxt = hwdata[7:0];
        end
    end

    // Configuration registers, each frozen while the clock enable is low
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_r <= `SLC_RST_BYTE;
        end else if (clk_en) begin
            main_r <= main_nxt;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            role_r <= `SLC_RST_BYTE;
        end else if (clk_en) begin
            role_r <= role_nxt;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sega_r <= `SLC_RST_BYTE;
        end else if (clk_en) begin
            sega_r <= sega_nxt;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            segb_r <= `SLC_RST_BYTE;
        end else if (clk_en) begin
            segb_r <= segb_nxt;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            segc_r <= `SLC_RST_BYTE;
        end else if (clk_en) begin
            segc_r <= segc_nxt;
        end
    end

    // Read data is picked in the address phase so the slave needs no wait state
    always @* begin
        hrdata_nxt = `SLC_RST_WORD;
        case (addr_idx)
            IDX_MAIN: hrdata_nxt[7:0] = main_r;
            IDX_ROLE: hrdata_nxt[7:0] = role_r;
            IDX_SEGA: hrdata_nxt[7:0] = sega_r;
            IDX_SEGB: hrdata_nxt[7:0] = segb_r;
            IDX_SEGC: hrdata_nxt[7:0] = segc_r;
            IDX_STAT: begin
                hrdata_nxt[`SLC_BIT_STAT_DIV] = bias_divider_on;
                hrdata_nxt[`SLC_BIT_STAT_FRAME] = frame_sel;
            end
            default: hrdata_nxt = `SLC_RST_WORD;
        endcase
    end

    // Bus side: always ready, always OKAY; a read right after a write sees the old byte
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= IDX_NONE;
            hrdata <= `SLC_RST_WORD;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            wr_pend_r <= take_wr;
            wr_idx_r <= addr_idx;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take_rd) begin
                hrdata <= hrdata_nxt;
            end
        end
    end

    genvar g;

    // Per dual pin: enable, role and level code
    generate
        for (g = 0; g < NDUAL; g = g + 1) begin : g_dual
            // RQ2 pin and master
            assign dual_act[g] = dual_en[g] & master;
            // RQ1 RQ7 RQ12 RQ13 RQ14 dual levels
            assign dual_lvl_nxt[2*g +: 2] = pin_level(dual_act[g], dual_role[g], frame,
                dual_pin_data[g]);
        end
    endgenerate

    // Per segment pin: oscillator claim, enable and level code
    generate
        for (g = 0; g < NSEG; g = g + 1) begin : g_seg
            // RQ9 oscillator claims pins
            assign osc_claim[g] = (g == `SLC_SEG14_IDX) ? osc_on_seg14 :
                ((g == `SLC_SEG15_IDX) ? osc_on_seg15 : 1'b0);
            assign seg_en[g] = seg_en_raw[g] & ~osc_claim[g];
            // RQ2 pin and master
            assign seg_act[g] = seg_en[g] & master;
            // RQ1 RQ12 RQ13 RQ14 segment levels
            assign seg_lvl_nxt[2*g +: 2] = pin_level(seg_act[g], 1'b1, frame, seg_pin_data[g]);
        end
    endgenerate

    // Master copy and divider path
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lcd_master_on <= 1'b0;
            bias_divider_on <= 1'b0;
        end else if (clk_en) begin
            lcd_master_on <= master;
            // RQ3 bias path
            bias_divider_on <= master;
        end
    end

    // Analog selects registered so the bias network sees no decode glitches
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bias_current_code <= 2'h0;
            frame_sel <= 1'b0;
        end else if (clk_en) begin
            // RQ5 current code out
            bias_current_code <= isel;
            // RQ4 frame out
            frame_sel <= frame;
        end
    end

    // Pin mux selects
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dual_pin_lcd_sel <= {NDUAL{1'b0}};
            seg_pin_lcd_sel <= {NSEG{1'b0}};
        end else if (clk_en) begin
            // RQ6 mux select
            dual_pin_lcd_sel <= dual_act;
            seg_pin_lcd_sel <= seg_act;
        end
    end

    // RQ10 direction bits never consulted
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dual_pin_level <= {(2*NDUAL){1'b0}};
            seg_pin_level <= {(2*NSEG){1'b0}};
        end else if (clk_en) begin
            dual_pin_level <= dual_lvl_nxt;
            seg_pin_level <= seg_lvl_nxt;
        end
    end
endmodule // slc_top
`default_nettype wire

// *** sim/slc_props.sv ***
// Port checker for the LCD pin control
`timescale 1ns/1ns
`default_nettype none
module slc_props #(parameter NDUAL = 6, parameter NSEG = 24) (
    input wire logic hclk, hresetn, osc_on_seg14, osc_on_seg15, // Clock, reset, pin claims
    input wire logic lcd_master_on, bias_divider_on, frame_sel, // Status outputs
    input wire logic [NSEG-1:0] seg_pin_data, seg_pin_lcd_sel, // Segment data and select
    input wire logic [NDUAL-1:0] dual_pin_lcd_sel, // Dual pin select
    input wire logic [2*NDUAL-1:0] dual_pin_level, // Dual pin levels
    input wire logic [2*NSEG-1:0] seg_pin_level // Segment pin levels
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_off; !lcd_master_on && !$past(lcd_master_on) |->
        dual_pin_level == 0 && seg_pin_level == 0; endproperty
    a_off: assert property (p_off) else $error("pin live with master off");
    property p_div; bias_divider_on == lcd_master_on; endproperty
    a_div: assert property (p_div) else $error("divider path wrong");
    property p_dsel; dual_pin_lcd_sel != 0 |-> lcd_master_on; endproperty
    a_dsel: assert property (p_dsel) else $error("dual pin taken");
    property p_ssel; seg_pin_lcd_sel != 0 |-> lcd_master_on; endproperty
    a_ssel: assert property (p_ssel) else $error("segment pin taken");
    property p_o14; $past(osc_on_seg14) |-> !seg_pin_lcd_sel[8]; endproperty
    a_o14: assert property (p_o14) else $error("pin 14 not freed");
    property p_o15; $past(osc_on_seg15) |-> !seg_pin_lcd_sel[9]; endproperty
    a_o15: assert property (p_o15) else $error("pin 15 not freed");
    property p_dlvl; dual_pin_level[1:0] != 0 |-> dual_pin_lcd_sel[0]; endproperty
    a_dlvl: assert property (p_dlvl) else $error("idle dual pin driven");
    property p_slvl; seg_pin_lcd_sel[0] |->
        seg_pin_level[1:0] == {$past(seg_pin_data[0]), frame_sel}; endproperty
    a_slvl: assert property (p_slvl) else $error("segment level wrong");
endmodule // slc_props
bind slc_top slc_props #(.NDUAL(NDUAL), .NSEG(NSEG)) u_props (.hclk(hclk),
    .hresetn(hresetn), .osc_on_seg14(osc_on_seg14), .osc_on_seg15(osc_on_seg15),
    .lcd_master_on(lcd_master_on), .bias_divider_on(bias_divider_on), .frame_sel(frame_sel),
    .seg_pin_data(seg_pin_data), .seg_pin_lcd_sel(seg_pin_lcd_sel),
    .dual_pin_lcd_sel(dual_pin_lcd_sel), .dual_pin_level(dual_pin_level),
    .seg_pin_level(seg_pin_level));
`default_nettype wire

// *** sim/slc_panel.sv ***
// Panel model: one pixel between dual pin 1 and segment pin 7
`timescale 1ns/1ns
`default_nettype none
module slc_panel (
    input wire logic [11:0] dual_pin_level, // Common side
    input wire logic [47:0] seg_pin_level, // Segment side
    output logic lit // Full swing across pixel
);
    // Only a full supply difference lights it
    assign lit = {dual_pin_level[3:2], seg_pin_level[3:2]} inside {4'hC, 4'h3};
endmodule // slc_panel
`default_nettype wire

// *** sim/test_slc_top.sv ***
// Bus-driven bench for the LCD pin control
`timescale 1ns/1ns
`default_nettype none
`include "slc_defs.vh"
module test_slc_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, osc14 = 1, osc15 = 0, ce = 1;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [5:0] dd = 6'h2A;
    logic [23:0] sd = 24'hA5A5A5;
    wire [31:0] hrdata;
    wire hreadyout, hresp, mon, div, fs, lit;
    wire [1:0] code;
    wire [5:0] dsel;
    wire [23:0] ssel;
    wire [11:0] dl;
    wire [47:0] sl;
    int err_total = 0, cmp_count = 0, cyc = 0;
    slc_top DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dual_pin_data(dd),
        .seg_pin_data(sd), .osc_on_seg14(osc14), .osc_on_seg15(osc15), .lcd_master_on(mon),
        .bias_divider_on(div), .bias_current_code(code), .frame_sel(fs),
        .dual_pin_lcd_sel(dsel), .seg_pin_lcd_sel(ssel), .dual_pin_level(dl),
        .seg_pin_level(sl));
    slc_panel u_panel (.dual_pin_level(dl), .seg_pin_level(sl), .lit(lit));
    initial forever #10 hclk = ~hclk;
    task chk(input logic [47:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task xfer(input logic w, input logic [31:0] a, d);
        hsel <= 1;
        htrans <= `SLC_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    function logic [1:0] lvl(input logic on, sg, d, f);
        return on ? {d, sg ? f : !f} : 2'h0;
    endfunction
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        for (int i = 0; i < 7; i++) begin
            xfer(0, i * 4, 0);
            chk(rd, 0);
        end
        chk(sl, 0);
        $display("reset test done");
        xfer(1, `SLC_OFS_ROLE, 32'h0000_00C5);
        for (int i = 8; i <= 16; i += 4) xfer(1, i, 32'hFFFF_FFFF);
        xfer(1, `SLC_OFS_MAIN, 32'hFFFF_FFEF);
        xfer(0, `SLC_OFS_MAIN, 0);
        chk(rd, 8'hEF);
        chk({fs, code, div}, 4'hE);
        chk({dsel, ssel, dl}, 0);
        chk(sl, 0);
        $display("master off test done");
        for (int m = 0; m < 8; m++) begin
            dd <= ~dd;
            xfer(1, `SLC_OFS_MAIN, {m[2:0], 5'h1F});
            repeat (2) @(posedge hclk);
            chk({fs, code, mon, div}, {m[2:0], 2'h3});
            chk({dsel, ssel}, 30'h3FFFFEFF);
            for (int p = 0; p < 6; p++)
                chk(dl[2*p+:2], lvl(1, p == 0 || p == 2, dd[p], m[2]));
            for (int k = 0; k < 24; k++)
                chk(sl[2*k+:2], lvl(k != 8, 1, sd[k], m[2]));
            chk(lit, !m[2] && m[0]);
            xfer(0, `SLC_OFS_STAT, 0);
            chk(rd, {1'b1, m[2], 4'h0});
        end
        osc14 <= 0;
        osc15 <= 1;
        repeat (2) @(posedge hclk);
        chk(ssel, 24'hFFFDFF);
        ce <= 0;
        osc15 <= 0;
        repeat (2) @(posedge hclk);
        chk(ssel, 24'hFFFDFF);
        ce <= 1;
        repeat (2) @(posedge hclk);
        chk(ssel, 24'hFFFFFF);
        chk({hreadyout, hresp}, 2'h2);
        xfer(1, `SLC_OFS_MAIN, 0);
        repeat (2) @(posedge hclk);
        chk({mon, div, dsel, dl}, 0);
        chk(sl, 0);
        $display("pin level test done");
        final_report;
    end
endmodule // test_slc_top
`default_nettype wire
